/* File: inc/page_map_cfg.svh */
`ifndef PAGE_MAP_CFG_SVH
`define PAGE_MAP_CFG_SVH
// Location that holds the page number on every page
`define PAGE_SEL_ADDR 8'hFF
// Page codes
`define PAGE_MASTER 8'h00
`define PAGE_CLKMON 8'h01
`define PAGE_INPUT 8'h02
`define PAGE_OUTPUT 8'h03
`define PAGE_PLL_A 8'h0A
`define PAGE_PLL_B 8'h0B
`define PAGE_PLL_C 8'h0C
`define PAGE_PLL_D 8'h0D
// Reset values
`define PAGE_SEL_RST 8'h00
`define PAGE_IDX_RST 3'h0
`define MEM_RST 8'h00
`endif

/* File: inc/page_map_pkg.sv */
package page_map_pkg;
  // One serial access as seen by the register map
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
  // Controller that owns a page
  typedef enum logic [7:0] {
    OWN_MASTER = 8'h01,
    OWN_CLKMON = 8'h02,
    OWN_INPUT = 8'h04,
    OWN_OUTPUT = 8'h08,
    OWN_PLL_A = 8'h10,
    OWN_PLL_B = 8'h20,
    OWN_PLL_C = 8'h40,
    OWN_PLL_D = 8'h80
  } page_owner_t;
endpackage

/* File: rtl/page_bank.sv */
`timescale 1ns/100ps
`default_nettype none
`include "page_map_cfg.svh"
// One controller's volatile memory; top location is never stored here
module page_bank #(
  parameter int DEPTH = 255
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Access
  input wire logic wr_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  // Elaboration check: the top address is never stored in a bank
  if (DEPTH < 1 || DEPTH > 255)
  begin : g_bad_depth
    $error("page_bank: DEPTH must be 1..255");
  end

  logic [7:0] mem_ff [DEPTH];
  logic [7:0] nxt_mem [DEPTH];

  // Next memory contents: only the addressed word changes
  always_comb
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      nxt_mem[i] = mem_ff[i];
    end
    if (wr_en && (int'(addr) < DEPTH))
    begin
      nxt_mem[addr] = wdata;
    end
  end

  // Reset clears the shadow so reads are defined before the first load
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem_ff[i] <= `MEM_RST;
      end
    end
    else
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem_ff[i] <= nxt_mem[i];
      end
    end
  end

  // Combinational read; unmapped words read zero
  assign rdata = (int'(addr) < DEPTH) ? mem_ff[addr] : 8'h00;
endmodule
`default_nettype wire

/* File: rtl/paged_register_map_select.sv */
// Functional notes
// RL1: Each page has its own 8-bit addressed volatile storage, same address differs per page.
// RL2: The top address on every page reads back the current page number.
// RL3: Writing a valid code to the top address on any page selects that page.
// RL4: Eight controllers, master and seven slaves, each owning one unique page.
// RL5: Page 0 is the master controller's page.
// RL6: Pages 1,2,3 monitor, input, output; pages A-D the four PLLs.
// RL7: Page 0 is a host-writable volatile shadow of master settings.
// RL8: Reset selects page 0.
`timescale 1ns/100ps
`default_nettype none
`include "page_map_cfg.svh"
// Host view: eight pages, each an 8-bit address space of its own
// The top address is the page register and exists on every page
// Select writes go to the page register only, never into a bank
// Refused codes keep the old page, so the host can always recover
// A refused code raises a one-cycle flag for status logic
// Read data is registered and follows the read strobe by one clock
// Read data holds until the next read, idle cycles do not disturb it
// A read and a write in the same cycle return the old contents
// A page change takes effect for the access after the select write
// Back-to-back accesses need no idle cycle
// Code and index registers move together; the index drives the banks
// Keeping the code avoids a reverse decode on every readback
// Owner lines are a pure decode of the index register
// Limitation: banks clear on reset; no nonvolatile load is modelled
// Limitation: the eight-page decode is fixed, hence the size check
// Trade-off: full read mux over all banks rather than a shared array
module paged_register_map_select #(
  parameter int NUM_PAGES = 8,
  parameter int DEPTH = 255
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Serial interface access
  input wire page_map_pkg::reg_req_t req,
  output logic [7:0] rdata,
  // Current selection
  output logic [7:0] page_sel,
  output page_map_pkg::page_owner_t page_owner,
  output logic bad_page_wr
);
  // Elaboration checks: the decode below serves exactly eight pages
  if (NUM_PAGES != 8)
  begin : g_bad_pages
    $error("paged_register_map_select: NUM_PAGES must be 8");
  end
  // The top address is never stored, so a bank holds at most 255 words
  if (DEPTH < 1 || DEPTH > 255)
  begin : g_bad_depth
    $error("paged_register_map_select: DEPTH must be 1..255");
  end

  // Map a page code to a bank index
  // Valid codes are 00-03 and 0A-0D; the gap and anything above
  // decode to index 8, whose top bit marks the code as refused
  function automatic logic [3:0] code_to_idx(input logic [7:0] code);
    case (code)
      `PAGE_MASTER: code_to_idx = 4'h0;
      `PAGE_CLKMON: code_to_idx = 4'h1;
      `PAGE_INPUT: code_to_idx = 4'h2;
      `PAGE_OUTPUT: code_to_idx = 4'h3;
      `PAGE_PLL_A: code_to_idx = 4'h4;
      `PAGE_PLL_B: code_to_idx = 4'h5;
      `PAGE_PLL_C: code_to_idx = 4'h6;
      `PAGE_PLL_D: code_to_idx = 4'h7;
      default: code_to_idx = 4'h8;
    endcase
  endfunction

  // One-hot bank enable for an index; each bank sees only its own bit
  function automatic logic [NUM_PAGES-1:0] idx_to_onehot(input logic [2:0] idx);
    idx_to_onehot = '0;
    idx_to_onehot[idx] = 1'b1;
  endfunction

  // Owner of a bank index; one line per controller
  function automatic page_map_pkg::page_owner_t idx_to_owner(input logic [2:0] idx);
    case (idx)
      3'h0: idx_to_owner = page_map_pkg::OWN_MASTER; // [RL5]
      3'h1: idx_to_owner = page_map_pkg::OWN_CLKMON; // [RL6]
      3'h2: idx_to_owner = page_map_pkg::OWN_INPUT; // [RL6]
      3'h3: idx_to_owner = page_map_pkg::OWN_OUTPUT; // [RL6]
      3'h4: idx_to_owner = page_map_pkg::OWN_PLL_A; // [RL6]
      3'h5: idx_to_owner = page_map_pkg::OWN_PLL_B;
      3'h6: idx_to_owner = page_map_pkg::OWN_PLL_C;
      3'h7: idx_to_owner = page_map_pkg::OWN_PLL_D;
      default: idx_to_owner = page_map_pkg::OWN_MASTER;
    endcase
  endfunction

  // Page state, refusal flag and read path
  logic [7:0] page_select_ff;
  logic [7:0] nxt_page_select;
  logic [2:0] page_idx_ff;
  logic [2:0] nxt_page_idx;
  logic bad_ff;
  logic nxt_bad;
  logic sel_hit;
  logic sel_wr;
  logic [3:0] wr_idx;
  logic [NUM_PAGES-1:0] bank_sel;
  logic [NUM_PAGES-1:0] bank_wr;
  logic [7:0] bank_rdata [NUM_PAGES];
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  // Address and code decode shared by the select, flag and bank paths
  assign sel_hit = (req.addr == `PAGE_SEL_ADDR);
  assign sel_wr = req.wr && sel_hit;
  assign wr_idx = code_to_idx(req.wdata);
  assign bank_sel = idx_to_onehot(page_idx_ff);

  // Page switch: invalid codes are ignored so the host cannot strand itself
  always_comb
  begin
    nxt_page_select = page_select_ff;
    nxt_page_idx = page_idx_ff;
    if (sel_wr && !wr_idx[3])
    begin
      nxt_page_select = req.wdata; // [RL3]
      nxt_page_idx = wr_idx[2:0]; // [RL3]
    end
  end

  // Page registers; code and index move together so they never disagree
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      page_select_ff <= `PAGE_SEL_RST; // [RL8]
      page_idx_ff <= `PAGE_IDX_RST; // [RL8]
    end
    else
    begin
      page_select_ff <= nxt_page_select;
      page_idx_ff <= nxt_page_idx;
    end
  end

  // Refused select write: a one-cycle flag, the page itself stays put
  always_comb
  begin
    nxt_bad = 1'b0;
    if (sel_wr && wr_idx[3])
    begin
      nxt_bad = 1'b1; // [RL3]
    end
  end

  // Flag register; any later cycle without a refusal clears it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bad_ff <= 1'b0;
    end
    else
    begin
      bad_ff <= nxt_bad;
    end
  end

  // One bank per controller; index 0 is the master shadow
  // Each bank decodes only its own enable, so the read mux is the only fan-in
  for (genvar g = 0; g < NUM_PAGES; g++)
  begin : g_bank
    // Select writes are kept out of every bank
    assign bank_wr[g] = req.wr && !sel_hit && bank_sel[g]; // [RL1] [RL4] [RL7]
    page_bank #(
      .DEPTH(DEPTH)
    ) u_bank (
      .clk(clk),
      .rst_n(rst_n),
      .wr_en(bank_wr[g]),
      .addr(req.addr),
      .wdata(req.wdata),
      .rdata(bank_rdata[g])
    );
  end

  // Registered read data, one cycle after the read strobe
  // Bank data is muxed by the index register, the banks never see a read
  always_comb
  begin
    nxt_rdata = rdata_ff;
    if (req.rd)
    begin
      if (sel_hit)
      begin
        nxt_rdata = page_select_ff; // [RL2]
      end
      else
      begin
        nxt_rdata = bank_rdata[page_idx_ff]; // [RL1]
      end
    end
  end

  // Read data register; holds between reads
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_ff <= 8'h00;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Owner decode of the selected page
  // Taken from the index, not the code, so it cannot show a refused code
  always_comb
  begin
    page_owner = idx_to_owner(page_idx_ff); // [RL4]
  end

  // Outputs straight from their registers
  assign rdata = rdata_ff;
  assign page_sel = page_select_ff;
  assign bad_page_wr = bad_ff;
endmodule
`default_nettype wire

/* File: verif/prm_props.sv */
`timescale 1ns/100ps
`default_nettype none
// Page select and decode checks
module prm_chk #(
  parameter int NUM_PAGES = 8,
  parameter int DEPTH = 255
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Observed ports
  input wire page_map_pkg::reg_req_t req,
  input wire logic [7:0] rdata,
  input wire logic [7:0] page_sel,
  input wire page_map_pkg::page_owner_t page_owner,
  input wire logic bad_page_wr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic s;
  logic v;
  // Select write and legality of its code
  assign s = req.wr && req.addr == 8'hFF;
  assign v = req.wdata < 8'h04 || (req.wdata > 8'h09 && req.wdata < 8'h0E);
  chk_sel_take: assert property (s && v |=> page_sel == $past(req.wdata))
    else $error("select not taken");
  chk_bad_drop: assert property (s && !v |=> bad_page_wr && $stable(page_sel))
    else $error("bad code not refused");
  chk_bad_cause: assert property (bad_page_wr |-> $past(s) && !$past(v))
    else $error("stray bad flag");
  chk_sel_hold: assert property (!s |=> $stable(page_sel))
    else $error("page moved");
  chk_sel_legal: assert property (page_sel < 8'h04 || (page_sel > 8'h09 && page_sel < 8'h0E))
    else $error("illegal page");
  chk_page_read: assert property (req.rd && !req.wr && req.addr == 8'hFF |=> rdata == page_sel)
    else $error("page readback");
  chk_owner_map: assert property (page_owner == (page_sel < 8'h04 ? 8'h01 << page_sel[1:0] : 8'h10 << (page_sel[1:0] - 2'h2)))
    else $error("owner decode");
  chk_reset_page: assert property ($rose(rst_n) |-> page_sel == 8'h00)
    else $error("reset page");
endmodule
bind paged_register_map_select prm_chk #(.NUM_PAGES(NUM_PAGES), .DEPTH(DEPTH)) u_chk (.clk(clk), .rst_n(rst_n),
  .req(req), .rdata(rdata), .page_sel(page_sel), .page_owner(page_owner), .bad_page_wr(bad_page_wr));
`default_nettype wire

/* File: verif/prm_host.sv */
`timescale 1ns/100ps
`default_nettype none
// Serial host; an idle cycle between accesses keeps each strobe one cycle long
module prm_host (
  // Clock
  input wire logic clk,
  // Access toward the map
  output page_map_pkg::reg_req_t req,
  input wire logic [7:0] rdata
);
  initial req = '0;
  // Drive after an edge, hold through the taking edge, then release
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    #1;
    req = '{w, !w, a, d};
    @(posedge clk);
    #1;
    q = rdata;
    req = '{1'b0, 1'b0, ~a, ~d};
  endtask
endmodule
`default_nettype wire

/* File: verif/paged_register_map_select_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module paged_register_map_select_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  page_map_pkg::reg_req_t req;
  logic [7:0] rdata;
  logic [7:0] page_sel;
  page_map_pkg::page_owner_t page_owner;
  logic bad_page_wr;
  logic [7:0] q;
  int fail_count = 0;
  int comparisons = 0;
  logic [7:0] cd [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h0A, 8'h0B, 8'h0C, 8'h0D};
  logic [7:0] bad [4] = '{8'h04, 8'h09, 8'h0E, 8'hFF};
  paged_register_map_select DUT (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata),
    .page_sel(page_sel), .page_owner(page_owner), .bad_page_wr(bad_page_wr));
  prm_host host (.clk(clk), .req(req), .rdata(rdata));
  // 40 MHz clock
  always #12.5 clk = ~clk;
  // Compare one byte
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] s);
    comparisons++;
    if (s !== e)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // Verdict
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'b1;
    cmp("owner", 8'h01, page_owner);
    host.access(1'b0, 8'hFF, 8'h00, q);
    cmp("page", 8'h00, q);
    $display("reset test done");
    for (int i = 0; i < 8; i++)
    begin
      host.access(1'b1, 8'hFF, cd[i], q);
      cmp("owner", 8'h01 << i, page_owner);
      cmp("bad", 8'h00, {7'h00, bad_page_wr});
      host.access(1'b0, 8'hFF, 8'h00, q);
      cmp("page", cd[i], q);
      host.access(1'b1, 8'hFE, cd[i] ^ 8'h5A, q);
    end
    $display("select test done");
    // Same top data address on every page must hold its own value
    for (int i = 0; i < 8; i++)
    begin
      host.access(1'b1, 8'hFF, cd[i], q);
      host.access(1'b0, 8'hFE, 8'h00, q);
      cmp("data", cd[i] ^ 8'h5A, q);
    end
    $display("storage test done");
    foreach (bad[i])
    begin
      host.access(1'b1, 8'hFF, bad[i], q);
      cmp("bad", 8'h01, {7'h00, bad_page_wr});
      cmp("page", 8'h0D, page_sel);
    end
    $display("refuse test done");
    // Reset in mid-run, off the clock edge, must fall back to the master page
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    cmp("page", 8'h00, page_sel);
    cmp("owner", 8'h01, page_owner);
    host.access(1'b0, 8'hFF, 8'h00, q);
    cmp("page", 8'h00, q);
    $display("reset again test done");
    close_out();
  end
  // Hang guard
  initial
  begin
    #100000;
    fail_count++;
    close_out();
  end
endmodule
`default_nettype wire
